/* File: rtl/arfc_pkg.sv */
// Package holding constants and types for the converter result and clock control block.
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package arfc_pkg;

    //------------------------------------------------------------------------
    // Register byte addresses
    //------------------------------------------------------------------------
    localparam logic [7:0] addr_status_control = 8'h00;
    localparam logic [7:0] addr_result_high    = 8'h04;
    localparam logic [7:0] addr_result_low     = 8'h08;
    localparam logic [7:0] addr_clock_config   = 8'h0c;
    localparam logic [7:0] addr_irq_status     = 8'h10;
    localparam logic [7:0] addr_irq_enable     = 8'h14;
    localparam logic [7:0] addr_irq_clear      = 8'h18;

    //------------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------------
    localparam int pos_done_flag   = 7;
    localparam int pos_irq_enable  = 6;
    localparam int pos_continuous  = 5;
    localparam int pos_prescale    = 5;
    localparam int pos_clock_sel   = 4;
    localparam int pos_justify     = 2;

    //------------------------------------------------------------------------
    // Reset values and codes
    //------------------------------------------------------------------------
    localparam logic [4:0] chan_power_off   = 5'h1f;
    localparam logic [4:0] chan_ref_high    = 5'h1d;
    localparam logic [4:0] chan_ref_low     = 5'h1e;
    localparam logic [4:0] chan_first_unused = 5'h18;
    localparam logic [2:0] prescale_reset   = 3'h0;
    localparam logic       clock_sel_reset  = 1'b0;
    localparam int         sample_cycles    = 17;

    typedef enum logic [1:0] {
        just_trunc8 = 2'h0,
        just_right  = 2'h1,
        just_left   = 2'h2,
        just_signed = 2'h3
    } arfc_justify_type;

    localparam arfc_justify_type justify_reset = just_right;

    typedef enum {conv_idle, conv_run} arfc_conv_type;

    typedef struct packed {
        logic                         [4:0] channel;
        logic                               irq_en;
        logic                               cont;
        logic                               done_flag;
        logic                               irq_req;
        logic                         [2:0] prescale;
        logic                               clock_sel;
        arfc_justify_type                   justify;
        logic                         [7:0] result_high;
        logic                         [7:0] result_low;
        logic                               frozen;
        logic                         [3:0] div_count;
        logic                         [4:0] conv_count;
        arfc_conv_type                      conv_state;
        logic                         [1:0] irq_status;
        logic                         [1:0] irq_mask;
        logic                               aw_seen;
        logic                               w_seen;
        logic                        [7:0] aw_addr;
        logic                        [31:0] w_data;
        logic                               bvalid;
        logic                               rvalid;
        logic                        [31:0] rdata;
        logic                         [1:0] rresp;
        logic                         [1:0] bresp;
    } arfc_state_type;

endpackage

/* File: rtl/arfc_top.sv */
// Converter result formatting, channel decode and converter clock control with AXI4-Lite.
`timescale 1ns/1ps
module arfc_top #(
    parameter int result_width = 10
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Oscillator clock, sampled as a level in the mclk domain
    input  wire logic        oscillator_out_clock,
    // Analog side
    input  wire logic [9:0]  conv_result,
    input  wire logic        conv_complete,
    input  wire logic        stop_mode,
    output logic      [4:0]  mux_select,
    output logic             select_ext_input,
    output logic             select_high_ref,
    output logic             select_low_ref,
    output logic             converter_power_off,
    output logic             result_unknown,
    output logic             converter_clock_en,
    output logic             conv_start,
    output logic             conv_abort,
    // Interrupt
    output logic             irq,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    arfc_pkg::arfc_state_type state;
    arfc_pkg::arfc_state_type next_state;

    logic       osc_prev;
    logic       osc_rise;
    logic       in_tick;
    logic       div_tick;
    logic [4:0] div_ratio;
    logic       wr_fire;
    logic       rd_fire;
    logic [7:0] wr_addr;
    logic [9:0] rbits;
    logic       conv_ok;
    logic       done_event;

    //------------------------------------------------------------------------
    // Input clock selection and prescaler
    //------------------------------------------------------------------------
    // The oscillator is treated as a level; its rising edge gives a one-cycle tick.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= oscillator_out_clock;
        end
    end
    assign osc_rise = oscillator_out_clock & ~osc_prev;
    assign in_tick  = state.clock_sel ? 1'b1 : osc_rise;

    always_comb begin
        case (state.prescale)
            3'h0:    div_ratio = 5'h01;
            3'h1:    div_ratio = 5'h02;
            3'h2:    div_ratio = 5'h04;
            3'h3:    div_ratio = 5'h08;
            default: div_ratio = 5'h10;
        endcase
    end
    assign div_tick = in_tick & ({1'b0, state.div_count} == div_ratio - 5'h01);

    //------------------------------------------------------------------------
    // Channel decode
    //------------------------------------------------------------------------
    always_comb begin
        mux_select          = state.channel;
        select_high_ref     = state.channel == arfc_pkg::chan_ref_high;
        select_low_ref      = state.channel == arfc_pkg::chan_ref_low;
        converter_power_off = state.channel == arfc_pkg::chan_power_off;
        select_ext_input    = state.channel < arfc_pkg::chan_first_unused;
        // Unused codes are flagged so results are not trusted.
        result_unknown      = ~select_ext_input & ~select_high_ref
                              & ~select_low_ref & ~converter_power_off;
    end
    assign conv_ok = ~converter_power_off & ~stop_mode;

    //------------------------------------------------------------------------
    // Result formatting
    //------------------------------------------------------------------------
    assign rbits      = conv_result;
    assign done_event = (state.conv_state == arfc_pkg::conv_run) & conv_complete & conv_ok;

    assign wr_fire = state.aw_seen & state.w_seen & ~state.bvalid;
    assign wr_addr = state.aw_addr;
    assign rd_fire = s_axi_arvalid & ~state.rvalid;

    always_comb begin
        next_state = state;
        // Bus write channels.
        if (s_axi_awvalid & ~state.aw_seen & ~state.bvalid) begin
            next_state.aw_seen = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~state.w_seen & ~state.bvalid) begin
            next_state.w_seen = 1'b1;
            next_state.w_data = s_axi_wdata;
        end
        if (state.bvalid & s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.rvalid & s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // Prescaler count.
        if (in_tick) begin
            next_state.div_count = div_tick ? 4'h0 : state.div_count + 4'h1;
        end

        // Conversion abort: stop mode or power off ends a running conversion.
        conv_start = 1'b0;
        conv_abort = 1'b0;
        if (stop_mode | converter_power_off) begin
            conv_abort = state.conv_state == arfc_pkg::conv_run;
            next_state.conv_state = arfc_pkg::conv_idle;
        end

        // Conversion end: format and load results; after a high-byte read, only 8-bit truncation loads until the low byte is read.
        if (done_event) begin
            if (state.justify == arfc_pkg::just_trunc8) begin
                next_state.result_low  = rbits[9:2];
                next_state.result_high = 8'h00;
            end else if (!state.frozen) begin
                case (state.justify)
                    arfc_pkg::just_right: begin
                        next_state.result_high = {6'h00, rbits[9:8]};
                        next_state.result_low  = rbits[7:0];
                    end
                    arfc_pkg::just_left: begin
                        next_state.result_high = rbits[9:2];
                        next_state.result_low  = {rbits[1:0], 6'h00};
                    end
                    default: begin
                        next_state.result_high = {~rbits[9], rbits[8:2]};
                        next_state.result_low  = {rbits[1:0], 6'h00};
                    end
                endcase
            end
            if (state.irq_en) begin
                next_state.irq_req = 1'b1;
            end else begin
                next_state.done_flag = 1'b1;
            end
            next_state.irq_status[0] = 1'b1;
            if (!state.cont) begin
                next_state.conv_state = arfc_pkg::conv_idle;
            end
        end
        if (conv_complete & (state.conv_state != arfc_pkg::conv_run)) begin
            next_state.irq_status[1] = 1'b1;
        end

        // Bus write effects.
        if (wr_fire) begin
            next_state.aw_seen = 1'b0;
            next_state.w_seen  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = 2'h0;
            case (wr_addr)
                arfc_pkg::addr_status_control: begin
                    if (s_axi_wstrb[0]) begin
                        next_state.channel    = state.w_data[4:0];
                        next_state.cont       = state.w_data[arfc_pkg::pos_continuous];
                        next_state.irq_en     = state.w_data[arfc_pkg::pos_irq_enable];
                        next_state.irq_req    = done_event & state.irq_en;
                        next_state.conv_state = arfc_pkg::conv_run;
                        conv_start            = 1'b1;
                    end
                end
                arfc_pkg::addr_clock_config: begin
                    if (s_axi_wstrb[0]) begin
                        next_state.prescale  = state.w_data[7:5];
                        next_state.clock_sel = state.w_data[arfc_pkg::pos_clock_sel];
                        next_state.justify   = arfc_pkg::arfc_justify_type'(state.w_data[3:2]);
                    end
                end
                arfc_pkg::addr_irq_enable: begin
                    next_state.irq_mask = state.w_data[1:0];
                end
                arfc_pkg::addr_irq_clear: begin
                    // A same-cycle event wins over the clear for a bit not already set; a pending bit is cleared.
                    next_state.irq_status = (state.irq_status & ~state.w_data[1:0])
                                            | next_state.irq_status & ~state.irq_status;
                end
                arfc_pkg::addr_result_high,
                arfc_pkg::addr_result_low,
                arfc_pkg::addr_irq_status: begin
                end
                default: begin
                    next_state.bresp = 2'h2;
                end
            endcase
        end

        // Continuous mode restarts at each end.
        if (done_event & state.cont) begin
            conv_start = 1'b1;
        end

        // Bus reads and their side effects.
        if (rd_fire) begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = 2'h0;
            next_state.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                arfc_pkg::addr_status_control: begin
                    next_state.rdata[7:0] = {state.done_flag & ~state.irq_en,
                                             state.irq_en, state.cont, state.channel};
                end
                arfc_pkg::addr_result_high: begin
                    next_state.rdata[7:0] = state.result_high;
                    if (state.justify != arfc_pkg::just_trunc8) begin
                        next_state.frozen = 1'b1;
                    end
                end
                arfc_pkg::addr_result_low: begin
                    next_state.rdata[7:0] = state.result_low;
                    next_state.frozen     = 1'b0;
                    // A completion in this same cycle keeps its flag.
                    next_state.done_flag  = done_event & ~state.irq_en;
                    next_state.irq_req    = done_event & state.irq_en;
                end
                arfc_pkg::addr_clock_config: begin
                    next_state.rdata[7:0] = {state.prescale, state.clock_sel,
                                             state.justify, 2'h0};
                end
                arfc_pkg::addr_irq_status: begin
                    next_state.rdata[1:0] = state.irq_status;
                end
                arfc_pkg::addr_irq_enable: begin
                    next_state.rdata[1:0] = state.irq_mask;
                end
                arfc_pkg::addr_irq_clear: begin
                end
                default: begin
                    next_state.rresp = 2'h2;
                end
            endcase
        end
    end

    //------------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state            <= '0;
            state.channel    <= arfc_pkg::chan_power_off;
            state.prescale   <= arfc_pkg::prescale_reset;
            state.clock_sel  <= arfc_pkg::clock_sel_reset;
            state.justify    <= arfc_pkg::justify_reset;
            state.conv_state <= arfc_pkg::conv_idle;
        end else begin
            state <= next_state;
        end
    end

    //------------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------------
    // The analog core steps only on converter clock ticks; software keeps these near 1 MHz.
    assign converter_clock_en = div_tick & conv_ok & (state.conv_state == arfc_pkg::conv_run);
    assign irq           = state.irq_req | (|(state.irq_status & state.irq_mask));
    assign s_axi_awready = ~state.aw_seen & ~state.bvalid;
    assign s_axi_wready  = ~state.w_seen & ~state.bvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = ~state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;

endmodule

/* File: sim/adc_result_format_and_clock_control_test.sv */
// Self-checking bench for the converter result and clock control block.
`timescale 1ns/1ps
module adc_result_format_and_clock_control_test;
    logic        mclk = 1'b0, resetn = 1'b0, osc = 1'b0, stop_mode = 1'b0;
    logic [9:0]  conv_result, sample_value = 10'h0;
    logic        conv_complete, clk_en, conv_start, conv_abort, irq;
    logic [4:0]  mux_select;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          miscompares = 0, comparisons = 0, cycles = 0, starts = 0;
    logic [34:0] expq[$];
    logic [34:0] note;

    arfc_top uut (.mclk(mclk), .resetn(resetn), .oscillator_out_clock(osc),
        .conv_result(conv_result), .conv_complete(conv_complete), .stop_mode(stop_mode),
        .mux_select(mux_select), .select_ext_input(), .select_high_ref(), .select_low_ref(),
        .converter_power_off(), .result_unknown(), .converter_clock_en(clk_en),
        .conv_start(conv_start), .conv_abort(conv_abort), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    arfc_analog_model model (.mclk(mclk), .resetn(resetn), .conv_start(conv_start),
        .conv_abort(conv_abort), .converter_clock_en(clk_en), .sample_value(sample_value),
        .conv_result(conv_result), .conv_complete(conv_complete));

    always #2.5 mclk = ~mclk;

    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The oscillator rises every eight cycles; the bound covers the run.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles[1:0] == 2'h3) osc <= ~osc;
        if (cycles == 30000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Negedge values equal what the next rising edge samples.
    always @(negedge mclk) begin
        if (conv_start) starts++;
        if (rvalid && rready) begin
            note = expq.pop_front();
            check({30'h0, rresp}, {30'h0, note[33:32]});
            if (!note[34]) check(rdata, note[31:0]);
        end
    end

    task automatic axi_write(input logic [7:0] addr, input logic [7:0] data);
        logic a, w, b;
        @(posedge mclk);
        awaddr <= addr;
        wdata <= {24'h0, data};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge mclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            @(posedge mclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        check({30'h0, bresp}, 32'h0);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] addr, input logic [34:0] exp);
        logic a, r;
        expq.push_back(exp);
        @(posedge mclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            a = arvalid && arready;
            r = rvalid && rready;
            @(posedge mclk);
            if (a) arvalid <= 1'b0;
        end while (!r);
        rready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] d);
        axi_read(addr, {3'h0, 24'h0, d});
    endtask

    task automatic wait_done();
        @(negedge mclk);
        while (!conv_complete) @(negedge mclk);
    endtask

    task automatic convert(input logic [7:0] st, input logic [9:0] v);
        sample_value <= v;
        axi_write(8'h00, st);
        wait_done();
    endtask

    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
        case (m)
            2'h0: fmt = {8'h0, v[9:2]};
            2'h1: fmt = {6'h0, v};
            2'h2: fmt = {v, 6'h0};
            default: fmt = {~v[9], v[8:0], 6'h0};
        endcase
    endfunction

    initial begin
        logic [4:0] codes[8] = '{5'h10, 5'h13, 5'h17, 5'h18, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
        logic [7:0] pcfg[7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0, 8'h00};
        int         pgap[7] = '{1, 2, 4, 8, 16, 16, 8};
        logic [9:0] v;
        logic [15:0] e;
        int         gap;
        void'($urandom(32'h55e7b3ba));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rd(8'h0c, 8'h04);
        rd(8'h00, 8'h1f);
        foreach (codes[i]) begin
            axi_write(8'h00, {3'h0, codes[i]});
            check({27'h0, mux_select}, {27'h0, codes[i]});
        end
        for (int m = 0; m < 4; m++) begin
            v = 10'($urandom());
            e = fmt(2'(m), v);
            axi_write(8'h0c, 8'h10 | 8'(m << 2));
            convert(8'h00, v);
            rd(8'h00, 8'h80);
            rd(8'h04, e[15:8]);
            rd(8'h08, e[7:0]);
            rd(8'h00, 8'h00);
        end
        axi_write(8'h0c, 8'h14);
        v = 10'($urandom());
        convert(8'h00, v);
        rd(8'h04, {6'h0, v[9:8]});
        convert(8'h00, ~v);
        rd(8'h08, v[7:0]);
        rd(8'h04, {6'h0, v[9:8]});
        rd(8'h08, v[7:0]);
        convert(8'h00, ~v);
        e = {6'h0, ~v};
        rd(8'h04, e[15:8]);
        axi_write(8'h0c, 8'h10);
        convert(8'h00, v);
        rd(8'h04, 8'h00);
        convert(8'h00, ~v);
        rd(8'h08, e[9:2]);
        foreach (pcfg[i]) begin
            axi_write(8'h0c, pcfg[i]);
            axi_write(8'h00, 8'h00);
            do @(negedge mclk); while (!clk_en);
            gap = 0;
            do begin
                @(negedge mclk);
                gap++;
            end while (!clk_en);
            check(32'(gap), 32'(pgap[i]));
            wait_done();
        end
        convert(8'h40, v);
        @(negedge mclk);
        check({31'h0, irq}, 32'h1);
        rd(8'h00, 8'h40);
        axi_read(8'h08, {1'b1, 34'h0});
        @(negedge mclk);
        check({31'h0, irq}, 32'h0);
        convert(8'h40, v);
        axi_write(8'h00, 8'h1f);
        @(negedge mclk);
        check({31'h0, irq}, 32'h0);
        axi_write(8'h14, 8'h01);
        @(negedge mclk);
        check({31'h0, irq}, 32'h1);
        axi_write(8'h18, 8'h03);
        @(negedge mclk);
        check({31'h0, irq}, 32'h0);
        rd(8'h18, 8'h00);
        axi_read(8'h1c, {1'b1, 2'h2, 32'h0});
        starts = 0;
        axi_write(8'h00, 8'h20);
        repeat (3) wait_done();
        check({31'h0, starts >= 3}, 32'h1);
        @(posedge mclk);
        stop_mode <= 1'b1;
        starts = 0;
        repeat (20) begin
            @(negedge mclk);
            if (clk_en) starts++;
        end
        check(32'(starts), 32'h0);
        @(posedge mclk);
        stop_mode <= 1'b0;
        axi_write(8'h00, 8'h1f);
        give_verdict();
    end
endmodule

/* File: sim/arfc_analog_model.sv */
// Behavioural model of the analog converter core.
`timescale 1ns/1ps
module arfc_analog_model #(
    parameter int ticks_per_conv = 4
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Control from the block; sample_value comes from the bench
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic       converter_clock_en,
    input  wire logic [9:0] sample_value,
    // Result to the block
    output logic      [9:0] conv_result,
    output logic            conv_complete
);
    logic       busy;
    logic [4:0] ticks;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            ticks <= 5'h0;
            conv_complete <= 1'b0;
            conv_result <= 10'h0;
        end else begin
            conv_complete <= 1'b0;
            // The bus toggles outside the completion cycle so a stale value is never reused.
            conv_result <= ~conv_result;
            if (conv_abort) begin
                busy <= 1'b0;
            end else if (conv_start) begin
                busy <= 1'b1;
                ticks <= 5'h0;
            end else if (busy && converter_clock_en) begin
                ticks <= ticks + 5'h1;
                if (ticks == 5'(ticks_per_conv - 1)) begin
                    busy <= 1'b0;
                    conv_complete <= 1'b1;
                    conv_result <= sample_value;
                end
            end
        end
    end
endmodule

/* File: sim/arfc_props.sv */
// Checker of the port behaviour of the result and clock control block.
`timescale 1ns/1ps
module arfc_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // Converter side
    input wire logic        stop_mode,
    input wire logic [4:0]  mux_select,
    input wire logic        select_ext_input,
    input wire logic        select_high_ref,
    input wire logic        select_low_ref,
    input wire logic        converter_power_off,
    input wire logic        result_unknown,
    input wire logic        converter_clock_en,
    input wire logic        conv_abort,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_EXT_INPUT: assert property (select_ext_input == (mux_select < 5'h18))
        else $error("input decode wrong");
    AST_REF_DECODE: assert property ((mux_select == 5'h1d) == select_high_ref
        && (mux_select == 5'h1e) == select_low_ref) else $error("reference decode wrong");
    AST_POWER_OFF: assert property (converter_power_off == (mux_select == 5'h1f))
        else $error("power off decode wrong");
    AST_UNUSED_CODE: assert property (result_unknown
        == (mux_select inside {[5'h18:5'h1c]})) else $error("unused code flag wrong");
    AST_STOP_IDLE: assert property (stop_mode [*2] |-> !converter_clock_en)
        else $error("clock runs in stop");
    AST_ABORT_IDLE: assert property (conv_abort |=> !converter_clock_en)
        else $error("clock runs after abort");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer not held");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
endmodule

bind arfc_top arfc_props u_props (
    .mclk(mclk), .resetn(resetn), .stop_mode(stop_mode), .mux_select(mux_select),
    .select_ext_input(select_ext_input), .select_high_ref(select_high_ref),
    .select_low_ref(select_low_ref), .converter_power_off(converter_power_off),
    .result_unknown(result_unknown), .converter_clock_en(converter_clock_en),
    .conv_abort(conv_abort), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
